/* File: qhp_pkg.sv */
package qhp_pkg;
  // Bus styles chosen by the strap
  localparam logic STRAP_SEPARATE = 1'b1;
  localparam logic STRAP_COMMON = 1'b0;
  // Bus widths and channel count
  localparam int NUM_CH = 4;
  localparam int DATA_W = 8;
  localparam int REG_SEL_W = 3;
  localparam int CH_SEL_W = 2;
  // Per-channel register bits steering the interrupt path
  localparam int MODEM_CTRL_IRQ_EN_BIT = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Register index of the modem control register inside a channel
  localparam logic [2:0] MODEM_CTRL_INDEX = 3'h4;
  // Register index of the interrupt enable register inside a channel
  localparam logic [2:0] IER_INDEX = 3'h1;
  // Access phase of the host strobe tracker
  typedef enum logic [1:0] {
    QHP_IDLE = 2'b00,
    QHP_ACTIVE = 2'b01
  } qhp_phase_t;
endpackage

/* File: qhp_chan_regs.sv */
`timescale 1ns/10ps
// Register bank of one channel: eight byte registers and its interrupt term.
module qhp_chan_regs #(
  parameter int DW = qhp_pkg::DATA_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Access from the bus port
  input wire logic wr_pulse,
  input wire logic [2:0] reg_sel,
  input wire logic [DW-1:0] wr_data,
  // Channel state
  output logic [DW-1:0] rd_data,
  output logic modem_irq_en,
  output logic irq_enabled,
  // Raw interrupt condition from the serial engine
  input wire logic irq_cond
);
  typedef struct packed {
    logic [7:0][DW-1:0] regs;
  } qhp_chan_state_t;

  qhp_chan_state_t st_ff;
  qhp_chan_state_t nxt_st;

  // ============================================================
  // Register storage
  always_comb begin
    nxt_st = st_ff;
    if (wr_pulse) begin
      nxt_st.regs[reg_sel] = wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Selected byte and interrupt gating terms
  assign rd_data = st_ff.regs[reg_sel];
  assign modem_irq_en = st_ff.regs[qhp_pkg::MODEM_CTRL_INDEX][qhp_pkg::MODEM_CTRL_IRQ_EN_BIT];
  assign irq_enabled = (|st_ff.regs[qhp_pkg::IER_INDEX]) & irq_cond;
endmodule

/* File: qhp_host_port.sv */
`timescale 1ns/10ps
// Operation
// - Strap high separate strobes, low common select
// - Common style: write is direction, reset low
// - Common style: channel interrupts wired-OR onto one
// - Three low address bits pick the register
// - Upper bits choose channel while select low
// - Separate style: upper bits are chip selects
// - Common select low enables the one channel chosen by upper bits
// - Separate style: only selected channel responds
// - Separate style: common select is channel one
// - Separate style: falling read strobe drives selected register
// - Falling write strobe stores data byte
// - Separate style: interrupt driven when enable, control bit, condition
// - Separate style: force input overrides modem control enable bit
module qhp_host_port #(
  parameter int NCH = qhp_pkg::NUM_CH,
  parameter int DW = qhp_pkg::DATA_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Bus style strap and device reset pin
  input wire logic bus_style_strap,
  input wire logic reset_pin,
  // Host strobes and selects
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic first_channel_select_n,
  input wire logic [qhp_pkg::CH_SEL_W-1:0] channel_select_bits,
  input wire logic fourth_channel_select_n,
  input wire logic [qhp_pkg::REG_SEL_W-1:0] register_select_bits,
  // Data bus as three signals
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  // Interrupts
  input wire logic interrupt_output_force,
  input wire logic [NCH-1:0] irq_cond,
  output logic [NCH-1:0] chan_irq,
  output logic [NCH-1:0] chan_irq_oe,
  output logic irq_req,
  output logic irq_req_oe,
  // Device reset seen by the channel logic
  output logic dev_reset
);
  typedef struct packed {
    qhp_pkg::qhp_phase_t rd_phase;
    qhp_pkg::qhp_phase_t wr_phase;
    logic [DW-1:0] data_out;
    logic data_oe;
    logic [NCH-1:0] chan_irq;
    logic [NCH-1:0] chan_irq_oe;
    logic irq_req;
    logic irq_req_oe;
    logic dev_reset;
  } qhp_state_t;

  qhp_state_t st_ff;
  qhp_state_t nxt_st;

  logic sep_style;
  logic [NCH-1:0] ch_sel;
  logic rd_req;
  logic wr_req;
  logic [NCH-1:0] wr_pulse;
  logic [NCH-1:0] modem_en;
  logic [NCH-1:0] irq_on;
  logic [NCH-1:0][DW-1:0] rd_bank;
  logic [DW-1:0] rd_sel;
  logic [qhp_pkg::CH_SEL_W-1:0] ch_idx;

  // ============================================================
  // Bus style decode
  // strap selects style
  assign sep_style = (bus_style_strap == qhp_pkg::STRAP_SEPARATE);

  // Channel selection for both styles
  always_comb begin
    ch_sel = '0;
    ch_idx = '0;
    if (sep_style) begin
      ch_sel[0] = ~first_channel_select_n;
      ch_sel[1] = ~channel_select_bits[0];
      ch_sel[2] = ~channel_select_bits[1];
      ch_sel[3] = ~fourth_channel_select_n;
      for (int i = NCH - 1; i >= 0; i--) begin
        if (ch_sel[i]) begin
          ch_idx = qhp_pkg::CH_SEL_W'(i);
        end
      end
    end else if (!first_channel_select_n) begin
      ch_idx = channel_select_bits;
      ch_sel[ch_idx] = 1'b1;
    end
  end

  // Access requests; common style treats write strobe as direction
  always_comb begin
    if (sep_style) begin
      rd_req = ~read_strobe_n & (|ch_sel);
      wr_req = ~write_strobe_n & (|ch_sel);
    end else begin
      rd_req = write_strobe_n & (|ch_sel);
      wr_req = ~write_strobe_n & (|ch_sel);
    end
  end

  // ============================================================
  // Channel register banks
  // One write pulse on the strobe's leading edge only; a strobe held low
  // for many cycles must not rewrite the register with later bus values.
  // relies on stable address
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign wr_pulse[g] = wr_req & (st_ff.wr_phase == qhp_pkg::QHP_IDLE) & (ch_idx == g);
      qhp_chan_regs #(
        .DW(DW)
      ) u_regs (
        .core_clk(core_clk),
        .srst(st_ff.dev_reset),
        .wr_pulse(wr_pulse[g]),
        .reg_sel(register_select_bits),
        .wr_data(data_in),
        .rd_data(rd_bank[g]),
        .modem_irq_en(modem_en[g]),
        .irq_enabled(irq_on[g]),
        .irq_cond(irq_cond[g])
      );
    end
  endgenerate

  assign rd_sel = rd_bank[ch_idx];

  // ============================================================
  // Next state of the port
  always_comb begin
    nxt_st = st_ff;
    nxt_st.dev_reset = srst | (sep_style ? reset_pin : ~reset_pin);
    nxt_st.wr_phase = wr_req ? qhp_pkg::QHP_ACTIVE : qhp_pkg::QHP_IDLE;
    nxt_st.rd_phase = rd_req ? qhp_pkg::QHP_ACTIVE : qhp_pkg::QHP_IDLE;
    nxt_st.data_oe = rd_req;
    if (rd_req) begin
      nxt_st.data_out = rd_sel;
    end
    if (sep_style) begin
      nxt_st.chan_irq = irq_on;
      nxt_st.chan_irq_oe = modem_en | {NCH{interrupt_output_force}};
      nxt_st.irq_req = 1'b0;
      nxt_st.irq_req_oe = 1'b0;
    end else begin
      nxt_st.chan_irq = '0;
      nxt_st.chan_irq_oe = '0;
      nxt_st.irq_req = |irq_on;
      nxt_st.irq_req_oe = |irq_on;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.dev_reset <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops
  assign data_out = st_ff.data_out;
  assign data_oe = st_ff.data_oe;
  assign chan_irq = st_ff.chan_irq;
  assign chan_irq_oe = st_ff.chan_irq_oe;
  assign irq_req = st_ff.irq_req;
  assign irq_req_oe = st_ff.irq_req_oe;
  assign dev_reset = st_ff.dev_reset;
endmodule

/* File: qhp_host_port_sva.sv */
`timescale 1ns/10ps
// ====
// Bus port checker
module qhp_host_port_sva (
  // Clock and straps
  input wire logic core_clk,
  input wire logic srst,
  input wire logic bus_style_strap,
  input wire logic reset_pin,
  // Host strobes
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic first_channel_select_n,
  input wire logic interrupt_output_force,
  // Watched outputs
  input wire logic data_oe,
  input wire logic [qhp_pkg::NUM_CH-1:0] chan_irq_oe,
  input wire logic irq_req,
  input wire logic irq_req_oe,
  input wire logic dev_reset
);
  // Straps only move under srst, so one clock and one disable serve all
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_RST_POL: assert property (reset_pin == bus_style_strap |=> dev_reset)
    else $error("reset pin polarity wrong");
  AST_SEP_RD: assert property (bus_style_strap && !read_strobe_n &&
    !first_channel_select_n && !dev_reset |=> data_oe)
    else $error("separate read not answered");
  AST_SEP_IDLE: assert property (bus_style_strap && read_strobe_n |=> !data_oe)
    else $error("data driven without read");
  AST_COM_RD: assert property (!bus_style_strap && !first_channel_select_n &&
    write_strobe_n && !dev_reset |=> data_oe)
    else $error("common read not answered");
  AST_COM_WR: assert property (!bus_style_strap &&
    !(write_strobe_n && !first_channel_select_n) |=> !data_oe)
    else $error("data driven on write or idle");
  AST_FORCE: assert property (bus_style_strap && interrupt_output_force |=>
    &chan_irq_oe)
    else $error("force left an output off");
  AST_COM_REQ: assert property (!bus_style_strap |->
    irq_req_oe == irq_req && chan_irq_oe == '0)
    else $error("common request mismatch");
  AST_SEP_REQ: assert property (bus_style_strap |-> !irq_req_oe)
    else $error("request driven in separate style");
endmodule

bind qhp_host_port qhp_host_port_sva u_sva (.*);

/* File: qhp_host_model.sv */
`timescale 1ns/10ps
// ====
// Host processor on the parallel bus
module qhp_host_model (
  // Clock and style
  input wire logic core_clk,
  input wire logic bus_style_strap,
  // Bus toward the port
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic first_channel_select_n,
  output logic [1:0] channel_select_bits,
  output logic fourth_channel_select_n,
  output logic [2:0] register_select_bits,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  // Released data lines toggle so a stale byte is never mistaken for data
  task automatic idle();
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    first_channel_select_n <= 1'b1;
    channel_select_bits <= 2'h3;
    fourth_channel_select_n <= 1'b1;
    data_in <= ~data_in;
  endtask
  initial begin
    data_in = 8'h5a;
    register_select_bits = 3'h0;
    idle();
  end
  // One access; q stays unknown if no answer comes
  task automatic access(input logic wr, input logic [1:0] ch, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    int n;
    q = 8'hxx;
    @(posedge core_clk);
    register_select_bits <= a;
    data_in <= d;
    write_strobe_n <= !wr;
    if (bus_style_strap) begin
      first_channel_select_n <= ch != 2'h0;
      channel_select_bits <= {ch != 2'h2, ch != 2'h1};
      fourth_channel_select_n <= ch != 2'h3;
      read_strobe_n <= wr;
    end else begin
      first_channel_select_n <= 1'b0;
      channel_select_bits <= ch;
      read_strobe_n <= 1'b0;
    end
    for (n = 0; n < 4; n++) begin
      @(posedge core_clk);
      if (wr || data_oe) break;
    end
    if (!wr && data_oe) q = data_out;
    idle();
  endtask
endmodule

/* File: qhp_host_port_tb.sv */
`timescale 1ns/10ps
// ====
// Bus port testbench
module qhp_host_port_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic bus_style_strap = 1'b1;
  logic reset_pin = 1'b0;
  logic interrupt_output_force = 1'b0;
  logic [3:0] irq_cond = 4'h0;
  logic [3:0] chan_irq, chan_irq_oe;
  logic read_strobe_n, write_strobe_n, first_channel_select_n, fourth_channel_select_n;
  logic [1:0] channel_select_bits;
  logic [2:0] register_select_bits;
  logic [7:0] data_in, data_out;
  logic data_oe, irq_req, irq_req_oe, dev_reset;
  int n_mismatch = 0;
  int cmp_count = 0;
  qhp_host_port DUT (.*);
  qhp_host_model host (.*);
  always #12.5 core_clk = ~core_clk;
  task automatic complete_run();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strap only changes under srst; reset pin parked at its idle level
  task automatic restart(input logic s);
    srst <= 1'b1;
    bus_style_strap <= s;
    reset_pin <= !s;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.access(1'b0, ch, a, 8'h00, q);
    check(q, e);
    if (^q === 1'bx) complete_run();
  endtask
  function automatic logic [7:0] pat(int c, int a);
    return 8'(c * 8 + a) ^ 8'ha5;
  endfunction
  // Fill every register of every channel, then read all back
  task automatic t_regs(input logic s);
    logic [7:0] q;
    restart(s);
    rd_chk(2'h3, 3'h7, qhp_pkg::REG_RESET);
    for (int c = 0; c < 4; c++)
      for (int a = 0; a < 8; a++)
        host.access(1'b1, 2'(c), 3'(a), pat(c, a), q);
    for (int c = 0; c < 4; c++)
      for (int a = 0; a < 8; a++)
        rd_chk(2'(c), 3'(a), pat(c, a));
  endtask
  task automatic t_irq_sep();
    logic [7:0] q;
    for (int c = 0; c < 4; c++)
      host.access(1'b1, 2'(c), qhp_pkg::MODEM_CTRL_INDEX, c[0] ? 8'h08 : 8'hf7, q);
    host.access(1'b1, 2'h2, qhp_pkg::IER_INDEX, 8'h00, q);
    irq_cond <= 4'hf;
    repeat (2) @(posedge core_clk);
    check(chan_irq, 4'hb);
    check(chan_irq_oe, 4'ha);
    interrupt_output_force <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(chan_irq_oe, 4'hf);
    interrupt_output_force <= 1'b0;
    irq_cond <= 4'h0;
  endtask
  task automatic t_com();
    irq_cond <= 4'h2;
    repeat (3) @(posedge core_clk);
    check({irq_req, irq_req_oe}, 2'h3);
    irq_cond <= 4'h0;
    repeat (3) @(posedge core_clk);
    check(irq_req, 1'b0);
    reset_pin <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_pin <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd_chk(2'h1, 3'h7, qhp_pkg::REG_RESET);
  endtask
  initial begin
    t_regs(qhp_pkg::STRAP_SEPARATE);
    t_irq_sep();
    t_regs(qhp_pkg::STRAP_COMMON);
    t_com();
    complete_run();
  end
endmodule
